// file: inc/prs_pkg.sv
// Shared constants for the process loop run sequencer
package prs_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_UNIT_SEL = 8'h04;
    localparam logic [7:0] OFS_UNIT_GAIN = 8'h08;
    localparam logic [7:0] OFS_UNIT_SCALE = 8'h0C;
    localparam logic [7:0] OFS_PRI_GAINS = 8'h10;
    localparam logic [7:0] OFS_SEC_GAIN = 8'h14;
    localparam logic [7:0] OFS_PRE_FREQ = 8'h18;
    localparam logic [7:0] OFS_PRE_EXIT = 8'h1C;
    localparam logic [7:0] OFS_PRE_DELAY = 8'h20;
    localparam logic [7:0] OFS_SLEEP_DT = 8'h24;
    localparam logic [7:0] OFS_SLEEP_FREQ = 8'h28;
    localparam logic [7:0] OFS_WAKE_LEVEL = 8'h2C;
    localparam logic [7:0] OFS_WAKE_MODE = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;
    localparam logic [7:0] OFS_SCALED_FB = 8'h38;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h3C;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h40;
    localparam logic [7:0] OFS_IRQ_EN = 8'h44;
    localparam logic [7:0] OFS_IN_FUNC = 8'h50;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_PRELUDE = 1;
    localparam int IRQ_W = 4;
    localparam int IRQ_PRE_EXIT = 0;
    localparam int IRQ_SLEEP = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_TRIP = 3;
    localparam int ST_BYPASS = 3;
    localparam int ST_SWAP = 4;
    localparam int ST_TRIP = 5;
    localparam logic [15:0] UNIT_GAIN_RST = 16'h0100;
    localparam logic [3:0] UNIT_SCALE_RST = 4'h8;
    // ------------------------------------------------------------
    // Display units, input functions and wake modes
    // ------------------------------------------------------------
    localparam logic [3:0] UNIT_PERCENT = 4'h0;
    localparam logic [3:0] UNIT_VOLT = 4'h7;
    localparam logic [3:0] UNIT_AMP = 4'h8;
    localparam logic [3:0] UNIT_KW = 4'h9;
    localparam logic [3:0] UNIT_HP = 4'hA;
    localparam logic [3:0] UNIT_DEG_C = 4'hB;
    localparam logic [3:0] UNIT_DEG_F = 4'hC;
    localparam logic [7:0] FUNC_LOOP_BYPASS = 8'h17;
    localparam logic [7:0] FUNC_GAIN_SWAP = 8'h18;
    localparam logic [1:0] WAKE_BELOW = 2'h0;
    localparam logic [1:0] WAKE_ABOVE = 2'h1;
    localparam logic [1:0] WAKE_BEYOND = 2'h2;
    // ------------------------------------------------------------
    // Timing and sequencer states
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRELUDE = 3'b001,
        ST_RUNPID = 3'b011,
        ST_SLEEPING = 3'b010,
        ST_TRIPPED = 3'b110
    } prs_state_t;
endpackage

// file: hdl/prs_hold_timer.sv
// Delay timer that expires once a condition has held long enough
`timescale 1ns/1ps
module prs_hold_timer #(
    parameter int W = 16
) (
    // Clock and control
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic tick,
    // Condition and limit
    input wire logic cond,
    input wire logic [W-1:0] limit,
    // Result
    output logic expired
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    initial begin
        if (W < 2) $error("prs_hold_timer: W too small");
    end

    always_comb begin
        cnt_next = cnt_reg;
        if (!cond) begin
            cnt_next = '0;
        end else if (tick && cnt_reg < limit) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg <= '0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
        end
    end

    assign expired = cond && (cnt_reg >= limit);
endmodule

// file: hdl/prs_unit_scaler.sv
// Sizes the feedback into the selected display unit
`timescale 1ns/1ps
module prs_unit_scaler #(
    parameter int W = 16
) (
    // Clock and control
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Value and factors
    input wire logic [W-1:0] value,
    input wire logic [15:0] gain,
    input wire logic [3:0] scale,
    // Result
    output logic [31:0] scaled
);
    logic [31:0] scaled_reg;
    logic [31:0] scaled_next;
    logic [W+15:0] prod;

    initial begin
        if (W > 16) $error("prs_unit_scaler: W above 16");
    end

    always_comb begin
        prod = value * gain;
        scaled_next = 32'(prod >> scale);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            scaled_reg <= '0;
        end else if (ce) begin
            scaled_reg <= scaled_next;
        end
    end

    assign scaled = scaled_reg;
endmodule

// file: hdl/prs_top.sv
// Run sequencer around the process loop: prelude, sleep, wake, bypass
`timescale 1ns/1ps
// Functional notes
// - Display unit codes 7 V, 8 A, 9 kW, 10 HP, 11 degC, 12 degF.
// - Feedback is sized by unit gain and unit scale for the display.
// - Input set to function 24 and active selects secondary proportional gain.
// - Run in prelude mode accelerates plainly up to prelude frequency.
// - Feedback above exit level ends prelude and starts closed loop.
// - Nonzero fail delay with feedback held low trips and blocks output.
// - Frequency below sleep frequency for sleep delay stops and sleeps.
// - Sleep keeps operation stopped until the selected wake condition holds.
// - Wake mode 0 wakes when feedback falls below wake level.
// - Wake mode 1 wakes when feedback rises above wake level.
// - Wake mode 2 wakes when reference minus feedback exceeds wake level.
// - Input set to function 23 on runs open loop; off resumes loop.
module prs_top #(
    parameter int FW = 16,
    parameter int N_IN = 7,
    parameter int TICK_CYC = prs_pkg::TICK_CYCLES,
    parameter logic [15:0] ACCEL_STEP = 16'h0010
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Terminals and process values
    input wire logic [N_IN-1:0] mf_in,
    input wire logic [FW-1:0] feedback,
    input wire logic [FW-1:0] reference,
    input wire logic [FW-1:0] loop_freq,
    input wire logic [FW-1:0] open_freq,
    // To power stage and loop arithmetic
    output logic [FW-1:0] freq_cmd,
    output logic drive_enable,
    output logic loop_active,
    output logic [15:0] prop_gain,
    output logic [15:0] integral_gain,
    output logic [3:0] display_unit_select,
    output logic irq
);
    initial begin
        if (FW > 16 || FW < 4) $error("prs_top: FW must be 4..16");
        if (N_IN < 1 || N_IN > 8) $error("prs_top: N_IN must be 1..8");
        if (TICK_CYC < 1) $error("prs_top: TICK_CYC must be positive");
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [1:0] ctrl_reg, ctrl_next;
    logic [3:0] unit_reg, unit_next;
    logic [15:0] ugain_reg, ugain_next;
    logic [3:0] uscale_reg, uscale_next;
    logic [31:0] pgains_reg, pgains_next;
    logic [15:0] sgain_reg, sgain_next;
    logic [FW-1:0] pre_freq_reg, pre_freq_next;
    logic [FW-1:0] pre_exit_reg, pre_exit_next;
    logic [15:0] pre_dly_reg, pre_dly_next;
    logic [15:0] sleep_dt_reg, sleep_dt_next;
    logic [FW-1:0] sleep_freq_reg, sleep_freq_next;
    logic [FW-1:0] wake_lvl_reg, wake_lvl_next;
    logic [1:0] wake_mode_reg, wake_mode_next;
    logic [prs_pkg::IRQ_W-1:0] istat_reg, istat_next;
    logic [prs_pkg::IRQ_W-1:0] ien_reg, ien_next;
    logic [7:0] func_reg [N_IN];
    logic [7:0] func_next [N_IN];
    logic [31:0] prdata_reg, prdata_next;
    logic slverr_reg, slverr_next;
    logic [31:0] scaled_fb;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic [prs_pkg::IRQ_W-1:0] ev;
    logic setup, wr_acc;
    logic [5:0] status;

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && ce;

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = '0;
        case (paddr)
            prs_pkg::OFS_CTRL: rd_mux = 32'(ctrl_reg);
            prs_pkg::OFS_UNIT_SEL: rd_mux = 32'(unit_reg);
            prs_pkg::OFS_UNIT_GAIN: rd_mux = 32'(ugain_reg);
            prs_pkg::OFS_UNIT_SCALE: rd_mux = 32'(uscale_reg);
            prs_pkg::OFS_PRI_GAINS: rd_mux = pgains_reg;
            prs_pkg::OFS_SEC_GAIN: rd_mux = 32'(sgain_reg);
            prs_pkg::OFS_PRE_FREQ: rd_mux = 32'(pre_freq_reg);
            prs_pkg::OFS_PRE_EXIT: rd_mux = 32'(pre_exit_reg);
            prs_pkg::OFS_PRE_DELAY: rd_mux = 32'(pre_dly_reg);
            prs_pkg::OFS_SLEEP_DT: rd_mux = 32'(sleep_dt_reg);
            prs_pkg::OFS_SLEEP_FREQ: rd_mux = 32'(sleep_freq_reg);
            prs_pkg::OFS_WAKE_LEVEL: rd_mux = 32'(wake_lvl_reg);
            prs_pkg::OFS_WAKE_MODE: rd_mux = 32'(wake_mode_reg);
            prs_pkg::OFS_STATUS: rd_mux = 32'(status);
            prs_pkg::OFS_SCALED_FB: rd_mux = scaled_fb;
            prs_pkg::OFS_IRQ_STAT: rd_mux = 32'(istat_reg);
            prs_pkg::OFS_IRQ_CLR: rd_mux = '0;
            prs_pkg::OFS_IRQ_EN: rd_mux = 32'(ien_reg);
            default: begin
                rd_hit = 1'b0;
                for (int i = 0; i < N_IN; i++) begin
                    if (paddr == 8'(prs_pkg::OFS_IN_FUNC + 4 * i)) begin
                        rd_hit = 1'b1;
                        rd_mux = 32'(func_reg[i]);
                    end
                end
            end
        endcase
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        unit_next = unit_reg;
        ugain_next = ugain_reg;
        uscale_next = uscale_reg;
        pgains_next = pgains_reg;
        sgain_next = sgain_reg;
        pre_freq_next = pre_freq_reg;
        pre_exit_next = pre_exit_reg;
        pre_dly_next = pre_dly_reg;
        sleep_dt_next = sleep_dt_reg;
        sleep_freq_next = sleep_freq_reg;
        wake_lvl_next = wake_lvl_reg;
        wake_mode_next = wake_mode_reg;
        ien_next = ien_reg;
        func_next = func_reg;
        prdata_next = prdata_reg;
        slverr_next = slverr_reg;
        istat_next = istat_reg;
        if (setup) begin
            prdata_next = pwrite ? '0 : rd_mux;
            slverr_next = !rd_hit;
        end
        if (wr_acc && rd_hit) begin
            case (paddr)
                prs_pkg::OFS_CTRL: ctrl_next = pwdata[1:0];
                prs_pkg::OFS_UNIT_SEL: begin
                    // Codes above degrees F are not a unit; kept out
                    if (pwdata[3:0] <= prs_pkg::UNIT_DEG_F) begin
                        unit_next = pwdata[3:0];
                    end
                end
                prs_pkg::OFS_UNIT_GAIN: ugain_next = pwdata[15:0];
                prs_pkg::OFS_UNIT_SCALE: uscale_next = pwdata[3:0];
                prs_pkg::OFS_PRI_GAINS: pgains_next = pwdata;
                prs_pkg::OFS_SEC_GAIN: sgain_next = pwdata[15:0];
                prs_pkg::OFS_PRE_FREQ: pre_freq_next = pwdata[FW-1:0];
                prs_pkg::OFS_PRE_EXIT: pre_exit_next = pwdata[FW-1:0];
                prs_pkg::OFS_PRE_DELAY: pre_dly_next = pwdata[15:0];
                prs_pkg::OFS_SLEEP_DT: sleep_dt_next = pwdata[15:0];
                prs_pkg::OFS_SLEEP_FREQ: sleep_freq_next = pwdata[FW-1:0];
                prs_pkg::OFS_WAKE_LEVEL: wake_lvl_next = pwdata[FW-1:0];
                prs_pkg::OFS_WAKE_MODE: wake_mode_next = pwdata[1:0];
                prs_pkg::OFS_IRQ_CLR: istat_next = istat_reg & ~pwdata[prs_pkg::IRQ_W-1:0];
                prs_pkg::OFS_IRQ_EN: ien_next = pwdata[prs_pkg::IRQ_W-1:0];
                default: begin
                    for (int i = 0; i < N_IN; i++) begin
                        if (paddr == 8'(prs_pkg::OFS_IN_FUNC + 4 * i)) begin
                            func_next[i] = pwdata[7:0];
                        end
                    end
                end
            endcase
        end
        // New events win over a clear in the same cycle
        istat_next = istat_next | ev;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_reg <= '0;
            unit_reg <= prs_pkg::UNIT_PERCENT;
            ugain_reg <= prs_pkg::UNIT_GAIN_RST;
            uscale_reg <= prs_pkg::UNIT_SCALE_RST;
            pgains_reg <= '0;
            sgain_reg <= '0;
            pre_freq_reg <= '0;
            pre_exit_reg <= '0;
            pre_dly_reg <= '0;
            sleep_dt_reg <= '0;
            sleep_freq_reg <= '0;
            wake_lvl_reg <= '0;
            wake_mode_reg <= prs_pkg::WAKE_BELOW;
            istat_reg <= '0;
            ien_reg <= '0;
            for (int i = 0; i < N_IN; i++) begin
                func_reg[i] <= '0;
            end
            prdata_reg <= '0;
            slverr_reg <= 1'b0;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
            unit_reg <= unit_next;
            ugain_reg <= ugain_next;
            uscale_reg <= uscale_next;
            pgains_reg <= pgains_next;
            sgain_reg <= sgain_next;
            pre_freq_reg <= pre_freq_next;
            pre_exit_reg <= pre_exit_next;
            pre_dly_reg <= pre_dly_next;
            sleep_dt_reg <= sleep_dt_next;
            sleep_freq_reg <= sleep_freq_next;
            wake_lvl_reg <= wake_lvl_next;
            wake_mode_reg <= wake_mode_next;
            istat_reg <= istat_next;
            ien_reg <= ien_next;
            func_reg <= func_next;
            prdata_reg <= prdata_next;
            slverr_reg <= slverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = ce;
    assign pslverr = slverr_reg && psel && penable;
    assign irq = |(istat_reg & ien_reg);

    // ------------------------------------------------------------
    // Terminal functions
    // ------------------------------------------------------------
    logic [N_IN-1:0] swap_hits, bypass_hits;
    logic gain_swap, loop_bypass;

    for (genvar g = 0; g < N_IN; g++) begin : g_term
        assign swap_hits[g] = mf_in[g] && func_reg[g] == prs_pkg::FUNC_GAIN_SWAP;
        assign bypass_hits[g] = mf_in[g] && func_reg[g] == prs_pkg::FUNC_LOOP_BYPASS;
    end
    assign gain_swap = |swap_hits;
    assign loop_bypass = |bypass_hits;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    prs_pkg::prs_state_t st_reg, st_next;
    logic [FW-1:0] freq_reg, freq_next;
    logic [31:0] tick_cnt_reg, tick_cnt_next;
    logic tick, run, pre_fail, sleep_due, wake_ok, in_pid;
    logic signed [FW:0] err;

    assign run = ctrl_reg[prs_pkg::CTRL_RUN];
    assign tick = tick_cnt_reg == 32'(TICK_CYC - 1);
    assign in_pid = st_reg == prs_pkg::ST_RUNPID && !loop_bypass;
    assign err = $signed({1'b0, reference}) - $signed({1'b0, feedback});

    always_comb begin
        tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
        case (wake_mode_reg)
            prs_pkg::WAKE_BELOW: wake_ok = feedback < wake_lvl_reg;
            prs_pkg::WAKE_ABOVE: wake_ok = feedback > wake_lvl_reg;
            prs_pkg::WAKE_BEYOND: wake_ok = err > $signed({1'b0, wake_lvl_reg});
            default: wake_ok = 1'b0;
        endcase
    end

    prs_hold_timer #(.W(16)) u_pre_timer (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .tick(tick),
        .cond(st_reg == prs_pkg::ST_PRELUDE && feedback <= pre_exit_reg),
        .limit(pre_dly_reg),
        .expired(pre_fail)
    );

    prs_hold_timer #(.W(16)) u_sleep_timer (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .tick(tick),
        .cond(in_pid && freq_reg < sleep_freq_reg),
        .limit(sleep_dt_reg),
        .expired(sleep_due)
    );

    prs_unit_scaler #(.W(FW)) u_scaler (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .value(feedback),
        .gain(ugain_reg),
        .scale(uscale_reg),
        .scaled(scaled_fb)
    );

    always_comb begin
        st_next = st_reg;
        freq_next = freq_reg;
        ev = '0;
        case (st_reg)
            prs_pkg::ST_IDLE: begin
                freq_next = '0;
                if (run) begin
                    st_next = ctrl_reg[prs_pkg::CTRL_PRELUDE] ?
                        prs_pkg::ST_PRELUDE : prs_pkg::ST_RUNPID;
                end
            end
            prs_pkg::ST_PRELUDE: begin
                if (tick) begin
                    if (pre_freq_reg - freq_reg > ACCEL_STEP[FW-1:0]) begin
                        freq_next = freq_reg + ACCEL_STEP[FW-1:0];
                    end else begin
                        freq_next = pre_freq_reg;
                    end
                end
                if (freq_reg > pre_freq_reg) begin
                    freq_next = pre_freq_reg;
                end
                if (feedback > pre_exit_reg) begin
                    st_next = prs_pkg::ST_RUNPID;
                    ev[prs_pkg::IRQ_PRE_EXIT] = 1'b1;
                end else if (pre_dly_reg != '0 && pre_fail) begin
                    st_next = prs_pkg::ST_TRIPPED;
                    freq_next = '0;
                    ev[prs_pkg::IRQ_TRIP] = 1'b1;
                end
            end
            prs_pkg::ST_RUNPID: begin
                freq_next = loop_bypass ? open_freq : loop_freq;
                if (in_pid && sleep_due) begin
                    st_next = prs_pkg::ST_SLEEPING;
                    freq_next = '0;
                    ev[prs_pkg::IRQ_SLEEP] = 1'b1;
                end
            end
            prs_pkg::ST_SLEEPING: begin
                freq_next = '0;
                if (wake_ok) begin
                    st_next = prs_pkg::ST_RUNPID;
                    ev[prs_pkg::IRQ_WAKE] = 1'b1;
                end
            end
            prs_pkg::ST_TRIPPED: freq_next = '0;
            default: st_next = prs_pkg::ST_IDLE;
        endcase
        if (!run) begin
            st_next = prs_pkg::ST_IDLE;
            freq_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg <= prs_pkg::ST_IDLE;
            freq_reg <= '0;
            tick_cnt_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
            freq_reg <= freq_next;
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign status = {st_reg == prs_pkg::ST_TRIPPED, gain_swap, loop_bypass, st_reg};
    assign freq_cmd = freq_reg;
    assign drive_enable = st_reg == prs_pkg::ST_PRELUDE || st_reg == prs_pkg::ST_RUNPID;
    assign loop_active = in_pid;
    assign prop_gain = gain_swap ? sgain_reg : pgains_reg[15:0];
    assign integral_gain = pgains_reg[31:16];
    assign display_unit_select = unit_reg;
endmodule

// file: sim/prs_plant.sv
// Power stage and process sensor model feeding back the process value
`timescale 1ns/1ps
module prs_plant (
    // Clock
    input wire logic clk,
    // Process level set by the bench
    input wire logic [15:0] target,
    // Sensor output
    output logic [15:0] feedback
);
    logic [15:0] lag_reg = '0;
    // Two-cycle sensor lag, so the sequencer never sees an instant answer
    always_ff @(posedge clk) begin
        lag_reg <= target;
        feedback <= lag_reg;
    end
endmodule

// file: sim/prs_top_assertions.sv
// Port checker for the run sequencer
`timescale 1ns/1ps
module prs_top_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    // Terminals and process values
    input wire logic [6:0] mf_in,
    input wire logic [15:0] loop_freq,
    // Outputs
    input wire logic [15:0] freq_cmd,
    input wire logic drive_enable,
    input wire logic loop_active,
    input wire logic [15:0] prop_gain,
    input wire logic [15:0] integral_gain,
    input wire logic [3:0] display_unit_select,
    input wire logic irq
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    logic wr;
    assign wr = psel && penable && pwrite;
    unit_range_a: assert property (display_unit_select <= 4'hC)
        else $error("display unit out of range");
    unit_write_a: assert property ($changed(display_unit_select)
        |-> $past(wr && paddr == prs_pkg::OFS_UNIT_SEL)) else $error("unit changed without write");
    int_gain_a: assert property ($changed(integral_gain)
        |-> $past(wr && paddr == prs_pkg::OFS_PRI_GAINS)) else $error("gain changed without write");
    prop_swap_a: assert property ($changed(prop_gain) |-> $changed(mf_in) || $past(wr))
        else $error("gain changed without cause");
    stop_zero_a: assert property (!drive_enable |-> freq_cmd == 16'h0000)
        else $error("frequency while stopped");
    run_drive_a: assert property (loop_active |-> drive_enable)
        else $error("loop active with output blocked");
    loop_track_a: assert property (loop_active && $past(loop_active) && $stable(loop_freq)
        |-> freq_cmd == loop_freq) else $error("frequency does not follow loop");
    irq_src_a: assert property ($rose(irq) |-> $past(wr) || $changed(drive_enable)
        || $changed(loop_active)) else $error("interrupt without event");
    cover property ($fell(drive_enable));
    cover property ($rose(loop_active));
    cover property ($rose(irq));
endmodule

// file: sim/prs_top_tb.sv
// Self-checking bench for the run sequencer
`timescale 1ns/1ps
module prs_top_tb;
    logic clk = 0, rstn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, rd, prdata;
    logic [6:0] mf_in = '0;
    logic [15:0] target = '0, reference = 16'h0300, loop_freq = 16'h0200, open_freq = 16'h0077;
    logic [15:0] feedback, freq_cmd, prop_gain, integral_gain;
    logic pready, pslverr, drive_enable, loop_active, irq;
    logic [3:0] display_unit_select;
    logic [15:0] hold_fb [3] = '{16'h0100, 16'h0100, 16'h0200};
    logic [15:0] wake_fb [3] = '{16'h00FF, 16'h0101, 16'h01FF};
    int mismatches = 0, comparisons = 0;
    always #4 clk = ~clk;
    prs_top #(.TICK_CYC(4)) u_prs_top (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mf_in(mf_in), .feedback(feedback),
        .reference(reference), .loop_freq(loop_freq), .open_freq(open_freq),
        .freq_cmd(freq_cmd), .drive_enable(drive_enable), .loop_active(loop_active),
        .prop_gain(prop_gain), .integral_gain(integral_gain),
        .display_unit_select(display_unit_select), .irq(irq));
    prs_plant u_prs_plant (.clk(clk), .target(target), .feedback(feedback));
    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            chk("pready", 0, 1);
            print_verdict;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_for(input int which, input logic val);
        for (int n = 0; n < 2000; n++) begin
            @(posedge clk);
            if ((which == 0 ? drive_enable : loop_active) === val) return;
        end
        chk("wait", 0, 1);
        print_verdict;
    endtask
    task done(input string s);
        @(posedge clk);
        $display("test %s done", s);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        apb(0, prs_pkg::OFS_UNIT_GAIN, 0);
        chk("unit_gain", rd, {16'h0000, prs_pkg::UNIT_GAIN_RST});
        apb(0, prs_pkg::OFS_UNIT_SCALE, 0);
        chk("unit_scale", rd, {28'h0, prs_pkg::UNIT_SCALE_RST});
        apb(0, 8'hFC, 0);
        chk("unmapped", {31'h0, err}, 1);
        for (int u = 7; u <= 13; u++) begin
            apb(1, prs_pkg::OFS_UNIT_SEL, u);
            done("unit");
            chk("unit_sel", {28'h0, display_unit_select}, u > 12 ? 12 : u);
        end
        apb(1, prs_pkg::OFS_UNIT_GAIN, 3);
        apb(1, prs_pkg::OFS_UNIT_SCALE, 1);
        target <= 16'h0300;
        repeat (6) @(posedge clk);
        apb(0, prs_pkg::OFS_SCALED_FB, 0);
        chk("scaled_fb", rd, 32'h0000_0480);
        apb(1, prs_pkg::OFS_IN_FUNC, {24'h0, prs_pkg::FUNC_GAIN_SWAP});
        apb(1, prs_pkg::OFS_IN_FUNC + 8'h04, {24'h0, prs_pkg::FUNC_LOOP_BYPASS});
        apb(1, prs_pkg::OFS_PRI_GAINS, 32'h0022_0011);
        apb(1, prs_pkg::OFS_SEC_GAIN, 32'h0000_0055);
        done("gains");
        chk("prop_gain", prop_gain, 16'h0011);
        chk("int_gain", integral_gain, 16'h0022);
        mf_in <= 7'h01;
        @(posedge clk);
        chk("prop_gain2", prop_gain, 16'h0055);
        mf_in <= 7'h00;
        target <= 16'h0000;
        apb(1, prs_pkg::OFS_PRE_FREQ, 32'h30);
        apb(1, prs_pkg::OFS_PRE_EXIT, 32'h200);
        apb(1, prs_pkg::OFS_CTRL, 32'h3);
        repeat (40) @(posedge clk);
        chk("pre_freq", freq_cmd, 16'h0030);
        chk("pre_loop", {drive_enable, loop_active}, 2'b10);
        target <= 16'h0200;
        repeat (20) @(posedge clk);
        chk("pre_equal", loop_active, 0);
        target <= 16'h0201;
        wait_for(1, 1);
        chk("irq_masked", irq, 0);
        apb(1, prs_pkg::OFS_IRQ_EN, 32'hF);
        done("prelude");
        chk("irq_on", irq, 1);
        apb(0, prs_pkg::OFS_IRQ_STAT, 0);
        chk("irq_stat", rd, 32'h1);
        apb(1, prs_pkg::OFS_IRQ_CLR, 32'hF);
        done("irq");
        chk("irq_off", irq, 0);
        apb(1, prs_pkg::OFS_SLEEP_FREQ, 32'h100);
        apb(1, prs_pkg::OFS_SLEEP_DT, 32'h2);
        apb(1, prs_pkg::OFS_WAKE_LEVEL, 32'h100);
        for (int m = 0; m < 3; m++) begin
            apb(1, prs_pkg::OFS_WAKE_MODE, m);
            target <= hold_fb[m];
            loop_freq <= 16'h0080;
            wait_for(0, 0);
            loop_freq <= 16'h0200;
            repeat (20) @(posedge clk);
            chk("asleep", {drive_enable, freq_cmd}, 0);
            target <= wake_fb[m];
            wait_for(0, 1);
            done("wake");
            chk("awake", loop_active, 1);
        end
        mf_in <= 7'h02;
        repeat (30) @(posedge clk);
        chk("bypass", {drive_enable, loop_active, freq_cmd}, {2'b10, open_freq});
        mf_in <= 7'h00;
        wait_for(1, 1);
        apb(1, prs_pkg::OFS_CTRL, 32'h0);
        target <= 16'h0000;
        apb(1, prs_pkg::OFS_PRE_DELAY, 32'h3);
        apb(1, prs_pkg::OFS_CTRL, 32'h3);
        wait_for(0, 1);
        wait_for(0, 0);
        repeat (10) @(posedge clk);
        apb(0, prs_pkg::OFS_IRQ_STAT, 0);
        chk("trip", {drive_enable, rd[prs_pkg::IRQ_TRIP]}, 2'b01);
        done("trip");
        print_verdict;
    end
endmodule
bind prs_top prs_top_checker u_prs_top_checker (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .mf_in(mf_in), .loop_freq(loop_freq),
    .freq_cmd(freq_cmd), .drive_enable(drive_enable), .loop_active(loop_active),
    .prop_gain(prop_gain), .integral_gain(integral_gain),
    .display_unit_select(display_unit_select), .irq(irq));
